// ==== core/pma_id_map.svh ====
// Register offsets, fixed values, bit positions and frame constants of the identity/status bank
`ifndef PMA_ID_MAP_SVH
`define PMA_ID_MAP_SVH

// ----------------------------------------------------------------
// Register offsets within the medium attachment device
// ----------------------------------------------------------------
`define OFS_STATUS1 16'h0001
`define OFS_ID_HIGH 16'h0002
`define OFS_ID_LOW 16'h0003
`define OFS_SPEED 16'h0004
`define OFS_PKG_LOW 16'h0005
`define OFS_PKG_HIGH 16'h0006
`define OFS_STATUS2 16'h0008
`define OFS_SIG_DETECT 16'h000A

// ----------------------------------------------------------------
// Fixed register values and bit positions
// ----------------------------------------------------------------
`define VAL_SPEED 16'h0011
`define VAL_PKG_LOW 16'h000B
`define VAL_PKG_HIGH 16'h4000
`define VAL_STATUS2_FIXED 16'hB000
`define VAL_ZERO 16'h0000
`define BIT_FAULT_SUMMARY 7
`define BIT_TX_FAULT 11
`define BIT_RX_FAULT 10
`define BIT_SIG_DETECT 0

// ----------------------------------------------------------------
// Management frame layout
// ----------------------------------------------------------------
`define DEV_ADDR 5'h01
`define PREAMBLE_BITS 6'h20
`define HEADER_LAST 6'h0C
`define TURN_LAST 6'h01
`define DATA_LAST 6'h0F
`define OP_ADDRESS 2'h0
`define OP_WRITE 2'h1
`define OP_POST_INC 2'h2
`define OP_READ 2'h3

`endif

// ==== core/pma_id_pkg.sv ====
// Types shared by the identity/status register bank
`default_nettype none
package pma_id_pkg;

  // ----------------------------------------------------------------
  // Management frame walker states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_HUNT,
    ST_HEADER,
    ST_TURN,
    ST_DATA
  } frame_state_t;

  // ----------------------------------------------------------------
  // Whole state of the bank, registered in one place
  // ----------------------------------------------------------------
  typedef struct packed {
    logic mdc_s1;
    logic mdc_s2;
    logic mdc_d;
    logic mdio_s1;
    logic mdio_s2;
    logic txf_s1;
    logic txf_s2;
    logic rxf_s1;
    logic rxf_s2;
    logic sig_s1;
    logic sig_s2;
    frame_state_t st;
    logic [5:0] cnt;
    logic [15:0] shift;
    logic [1:0] op;
    logic hit;
    logic rd_drive;
    logic [15:0] addr;
    logic [15:0] out_sh;
    logic mdio_o;
    logic mdio_oe_n;
    logic tx_lh;
    logic rx_lh;
    logic sig_r;
  } bank_state_t;

endpackage : pma_id_pkg
`default_nettype wire

// ==== core/pma_identity_status_regs.sv ====
// Identity and fault status registers of one channel's medium attachment, reached over management frames
`include "pma_id_map.svh"
`default_nettype none

module pma_identity_status_regs
  import pma_id_pkg::*;
#(
  parameter logic [4:0] PORT_ADDR = 5'h00,            // Port address this channel answers to
  parameter logic [21:0] MAKER_UNIQUE_CODE = 22'h2A5C31, // Arbitrary value
  parameter logic [5:0] MODEL_NUMBER = 6'h2D,          // Arbitrary value
  parameter logic [3:0] REVISION_NUMBER = 4'h3         // Arbitrary value
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe_n,
  input wire logic tx_fault,
  input wire logic rx_fault,
  input wire logic serial_input_signal_seen
);

  // ----------------------------------------------------------------
  // Identifier words
  // ----------------------------------------------------------------
  localparam logic [15:0] PART_ID_WORD_HIGH = MAKER_UNIQUE_CODE[21:6];
  localparam logic [15:0] PART_ID_WORD_LOW = {MAKER_UNIQUE_CODE[5:0], MODEL_NUMBER, REVISION_NUMBER};

  // Reset image: idle line, released pin, nothing latched
  localparam bank_state_t RESET_STATE = '{
    st: ST_HUNT,
    mdio_oe_n: 1'b1,
    default: '0
  };

  // ----------------------------------------------------------------
  // Register read decode
  // ----------------------------------------------------------------
  // Unmapped offsets read as zero so a station probing the space sees nothing
  function automatic logic [15:0] read_word(
    input logic [15:0] a,
    input logic txl,
    input logic rxl,
    input logic sig
  );
    logic [15:0] w;
    w = `VAL_ZERO;
    case (a)
      `OFS_STATUS1: begin
        w[`BIT_FAULT_SUMMARY] = txl | rxl;
      end
      `OFS_ID_HIGH: begin
        w = PART_ID_WORD_HIGH;
      end
      `OFS_ID_LOW: begin
        w = PART_ID_WORD_LOW;
      end
      `OFS_SPEED: begin
        w = `VAL_SPEED;
      end
      `OFS_PKG_LOW: begin
        w = `VAL_PKG_LOW;
      end
      `OFS_PKG_HIGH: begin
        w = `VAL_PKG_HIGH;
      end
      `OFS_STATUS2: begin
        w = `VAL_STATUS2_FIXED;
        w[`BIT_TX_FAULT] = txl;
        w[`BIT_RX_FAULT] = rxl;
      end
      `OFS_SIG_DETECT: begin
        w[`BIT_SIG_DETECT] = sig;
      end
      default: begin
        w = `VAL_ZERO;
      end
    endcase
    return w;
  endfunction : read_word

  // ----------------------------------------------------------------
  // State and per-cycle events
  // ----------------------------------------------------------------
  bank_state_t s_r;        // Registered state
  bank_state_t s_nxt;      // Next state
  logic mdc_rise;          // Management clock rising edge seen
  logic bit_in;            // Line level sampled with that edge
  logic [12:0] hdr;        // Completed header bits
  logic [15:0] word_in;    // Completed data bits of a frame
  logic load_go;           // Read word snapshot taken
  logic rd_clear;          // Status two being read: latches may clear
  logic addr_commit;       // Address frame accepted
  logic addr_inc;          // Post-read increment applied
  logic hit_now;           // Header addresses this device

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    load_go = 1'b0;
    rd_clear = 1'b0;
    addr_commit = 1'b0;
    addr_inc = 1'b0;
    // Edge and bit first: the words below must be built from this cycle's line level
    mdc_rise = s_r.mdc_s2 & ~s_r.mdc_d;
    bit_in = s_r.mdio_s2;
    hdr = {s_r.shift[11:0], bit_in};
    word_in = {s_r.shift[14:0], bit_in};
    hit_now = 1'b0;
    // Two flops on every pin before logic reads it
    s_nxt.mdc_s1 = mdc;
    s_nxt.mdc_s2 = s_r.mdc_s1;
    s_nxt.mdc_d = s_r.mdc_s2;
    s_nxt.mdio_s1 = mdio_in;
    s_nxt.mdio_s2 = s_r.mdio_s1;
    s_nxt.txf_s1 = tx_fault;
    s_nxt.txf_s2 = s_r.txf_s1;
    s_nxt.rxf_s1 = rx_fault;
    s_nxt.rxf_s2 = s_r.rxf_s1;
    s_nxt.sig_s1 = serial_input_signal_seen;
    s_nxt.sig_s2 = s_r.sig_s1;
    // Live signal detect, no latching
    s_nxt.sig_r = s_r.sig_s2;
    if (mdc_rise) begin
      case (s_r.st)
        // Count preamble ones, a zero after enough of them starts a frame
        ST_HUNT: begin
          if (bit_in) begin
            if (s_r.cnt != `PREAMBLE_BITS) begin
              s_nxt.cnt = s_r.cnt + 6'h01;
            end
          end else if (s_r.cnt == `PREAMBLE_BITS) begin
            s_nxt.st = ST_HEADER;
            s_nxt.cnt = '0;
            s_nxt.shift = '0;
          end else begin
            s_nxt.cnt = '0;
          end
        end
        // Second start bit, opcode, port and device address
        ST_HEADER: begin
          s_nxt.shift = word_in;
          s_nxt.cnt = s_r.cnt + 6'h01;
          if (s_r.cnt == `HEADER_LAST) begin
            // Only device address one reaches this bank
            hit_now = (hdr[12] == 1'b0) && (hdr[9:5] == PORT_ADDR) && (hdr[4:0] == `DEV_ADDR);
            s_nxt.op = hdr[11:10];
            s_nxt.hit = hit_now;
            s_nxt.rd_drive = hit_now & hdr[11];
            if (hit_now & hdr[11]) begin
              load_go = 1'b1;
              s_nxt.out_sh = read_word(s_r.addr, s_r.tx_lh, s_r.rx_lh, s_r.sig_r);
              rd_clear = (s_r.addr == `OFS_STATUS2);
            end
            s_nxt.st = ST_TURN;
            s_nxt.cnt = '0;
          end
        end
        // Turnaround: first bit left free, then a zero on a read
        ST_TURN: begin
          s_nxt.cnt = s_r.cnt + 6'h01;
          if (s_r.cnt != `TURN_LAST) begin
            if (s_r.rd_drive) begin
              s_nxt.mdio_o = 1'b0;
              s_nxt.mdio_oe_n = 1'b0;
            end
          end else begin
            if (s_r.rd_drive) begin
              s_nxt.mdio_o = s_r.out_sh[15];
            end
            s_nxt.st = ST_DATA;
            s_nxt.cnt = '0;
          end
        end
        // Sixteen data bits, most significant first
        ST_DATA: begin
          s_nxt.shift = word_in;
          s_nxt.out_sh = {s_r.out_sh[14:0], 1'b0};
          s_nxt.cnt = s_r.cnt + 6'h01;
          if (s_r.rd_drive) begin
            s_nxt.mdio_o = s_r.out_sh[14];
          end
          if (s_r.cnt == `DATA_LAST) begin
            s_nxt.st = ST_HUNT;
            s_nxt.cnt = '0;
            s_nxt.mdio_o = 1'b0;
            s_nxt.mdio_oe_n = 1'b1;
            s_nxt.rd_drive = 1'b0;
            // Write frames fall through here and touch nothing
            if (s_r.hit && s_r.op == `OP_ADDRESS) begin
              s_nxt.addr = word_in;
              addr_commit = 1'b1;
            end else if (s_r.hit && s_r.op == `OP_POST_INC) begin
              s_nxt.addr = s_r.addr + 16'h0001;
              addr_inc = 1'b1;
            end
          end
        end
        default: begin
          s_nxt.st = ST_HUNT;
          s_nxt.cnt = '0;
        end
      endcase
    end
    // Set wins over the read clear, so a fault in the read cycle survives
    s_nxt.tx_lh = s_r.txf_s2 | (s_r.tx_lh & ~rd_clear);
    s_nxt.rx_lh = s_r.rxf_s2 | (s_r.rx_lh & ~rd_clear);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Synchronous reset returns the whole struct to its image in one edge
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_r <= RESET_STATE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Pin drive straight from flops
  assign mdio_out = s_r.mdio_o;
  assign mdio_oe_n = s_r.mdio_oe_n;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  logic summary_fault;
  assign summary_fault = s_r.tx_lh | s_r.rx_lh;

  // Reset clears the latches with no status read, so every check is held off while
  // rst is high; otherwise a_summary_clear would report that drop as a lost fault.
  a_tx_fault_latch: assert property (s_r.txf_s2 |=> s_r.tx_lh)
    else $error("transmit fault not latched");
  a_rx_fault_latch: assert property (s_r.rxf_s2 |=> s_r.rx_lh)
    else $error("receive fault not latched");
  a_latch_holds: assert property ((s_r.tx_lh || s_r.rx_lh) && !rd_clear |=>
    (s_r.tx_lh || !$past(s_r.tx_lh)) && (s_r.rx_lh || !$past(s_r.rx_lh)))
    else $error("latched fault dropped without a read");
  a_summary_clear: assert property ($fell(summary_fault) |-> $past(rd_clear))
    else $error("summary fault cleared without status read");
  a_sig_follows: assert property (s_r.sig_s2 ##1 s_r.sig_s2 |-> s_r.sig_r)
    else $error("signal detect not following input");
  a_sig_drops: assert property (!s_r.sig_s2 |=> !s_r.sig_r)
    else $error("signal detect not dropping with input");
  a_addr_writes_ignored: assert property ($changed(s_r.addr) |-> $past(addr_commit || addr_inc))
    else $error("address changed without an address frame");
  a_id_high_word: assert property (load_go && s_r.addr == `OFS_ID_HIGH |=> s_r.out_sh == PART_ID_WORD_HIGH)
    else $error("first identifier word wrong");
  a_id_low_word: assert property (load_go && s_r.addr == `OFS_ID_LOW |=>
    s_r.out_sh[15:10] == MAKER_UNIQUE_CODE[5:0] && s_r.out_sh[9:4] == MODEL_NUMBER &&
    s_r.out_sh[3:0] == REVISION_NUMBER)
    else $error("second identifier word wrong");
  a_speed_word: assert property (load_go && s_r.addr == `OFS_SPEED |=> s_r.out_sh == `VAL_SPEED)
    else $error("speed word wrong");
  a_status2_fixed: assert property (load_go && s_r.addr == `OFS_STATUS2 |=>
    s_r.out_sh[15:12] == 4'hB && !s_r.out_sh[8])
    else $error("status two fixed bits wrong");
  a_status2_latches: assert property (load_go && s_r.addr == `OFS_STATUS2 |=>
    s_r.out_sh[`BIT_TX_FAULT] == $past(s_r.tx_lh) && s_r.out_sh[`BIT_RX_FAULT] == $past(s_r.rx_lh))
    else $error("status two fault bits wrong");
  a_read_drive: assert property (mdc_rise && s_r.st == ST_TURN && s_r.cnt != `TURN_LAST && s_r.rd_drive |=>
    !mdio_oe_n && !mdio_out)
    else $error("turnaround zero not driven");
  // The line must be free again before the station's next preamble
  a_data_release: assert property (mdc_rise && s_r.st == ST_DATA && s_r.cnt == `DATA_LAST |=> mdio_oe_n)
    else $error("line not released after data");
  // A frame for another port or device never turns the pin around
  a_foreign_silent: assert property (!s_r.hit |-> mdio_oe_n)
    else $error("line driven for a foreign frame");

  // Main scenarios the bench is expected to reach
  c_status2_read: cover property (load_go && s_r.addr == `OFS_STATUS2 && summary_fault);
  c_addr_frame: cover property (addr_commit);
  c_post_inc: cover property (addr_inc);
  c_fault_on_clear: cover property (rd_clear && s_r.txf_s2);
  c_signal_read: cover property (load_go && s_r.addr == `OFS_SIG_DETECT && s_r.sig_r);

endmodule : pma_identity_status_regs
`default_nettype wire

// ==== bench/mgmt_station.sv ====
// Management station model: clause 45 frames on a pulled-up data line
`default_nettype none

module mgmt_station (
  input wire logic ref_clk,
  input wire logic mdio_out,
  input wire logic mdio_oe_n,
  output logic mdc,
  output logic mdio_in,
  output logic clash
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Line state
  // ----------------------------------------------------------------
  logic drv_en = 1'b0; // Station drives the line
  logic drv_val = 1'b1; // Level driven by the station
  int half = 4; // Ref clock cycles per mdc phase, never below 4

  // Device enable wins; a released line floats high through the pull-up
  assign mdio_in = !mdio_oe_n ? mdio_out : (drv_en ? drv_val : 1'b1);

  // Clock stands low between frames
  initial begin
    mdc = 1'b0;
    clash = 1'b0;
  end

  // ----------------------------------------------------------------
  // One bit time: set up while mdc low, sample at the rising edge
  // ----------------------------------------------------------------
  task automatic bit_cyc(input logic en, input logic val, output logic smp);
    @(posedge ref_clk);
    drv_en <= en;
    drv_val <= val;
    repeat (half) @(posedge ref_clk);
    smp = mdio_in;
    // Both parties driving at once would hide a wrong answer
    if (en && !mdio_oe_n) begin
      clash <= 1'b1;
    end
    mdc <= 1'b1;
    repeat (half) @(posedge ref_clk);
    mdc <= 1'b0;
  endtask : bit_cyc

  // Whole frame with its own preamble; reads release the line after the header
  task automatic frame(input logic [1:0] op, input logic [4:0] port, input logic [4:0] dev,
                       input logic [15:0] wdata, output logic ta, output logic [15:0] rdata);
    logic [13:0] hdr;
    logic [17:0] wbits;
    logic s;
    hdr = {2'b00, op, port, dev};
    wbits = {2'b10, wdata};
    for (int i = 0; i < 32; i++) bit_cyc(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--) bit_cyc(1'b1, hdr[i], s);
    if (op[1]) begin
      bit_cyc(1'b0, 1'b1, s);
      bit_cyc(1'b0, 1'b1, ta);
      for (int i = 15; i >= 0; i--) bit_cyc(1'b0, 1'b1, rdata[i]);
    end else begin
      for (int i = 17; i >= 0; i--) bit_cyc(1'b1, wbits[i], s);
      ta = 1'b0;
      rdata = 16'hFFFF;
    end
    @(posedge ref_clk);
    drv_en <= 1'b0;
  endtask : frame
endmodule : mgmt_station
`default_nettype wire

// ==== bench/tb.sv ====
// Self-checking bench for the identity and fault status register bank
`include "pma_id_map.svh"
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Identity parameters and bench state
  // ----------------------------------------------------------------
  localparam logic [4:0] P_PORT = 5'h05; // Port of the channel
  localparam logic [21:0] P_MAKER = 22'h0D61E9; // Arbitrary value
  localparam logic [5:0] P_MODEL = 6'h1B; // Arbitrary value
  localparam logic [3:0] P_REV = 4'hA; // Arbitrary value
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic tx_fault = 1'b0;
  logic rx_fault = 1'b0;
  logic sig = 1'b0;
  logic tx_l = 1'b0; // Expected transmit latch
  logic rx_l = 1'b0; // Expected receive latch
  wire logic mdc, mdio_in, mdio_out, mdio_oe_n, clash;
  int n_fail = 0;
  int compares = 0;
  int seed = 64960;

  pma_identity_status_regs #(.PORT_ADDR(P_PORT), .MAKER_UNIQUE_CODE(P_MAKER), .MODEL_NUMBER(P_MODEL),
    .REVISION_NUMBER(P_REV)) i_pma_identity_status_regs (.ref_clk(ref_clk), .rst(rst), .mdc(mdc),
    .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n), .tx_fault(tx_fault),
    .rx_fault(rx_fault), .serial_input_signal_seen(sig));
  mgmt_station i_mgmt_station (.ref_clk(ref_clk), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n),
    .mdc(mdc), .mdio_in(mdio_in), .clash(clash));

  // ----------------------------------------------------------------
  // Expected word at an offset, from the bench's own latch copy
  // ----------------------------------------------------------------
  function automatic logic [15:0] exp_reg(input logic [15:0] ofs);
    case (ofs)
      16'h0001: return {8'h00, tx_l | rx_l, 7'h00};
      16'h0002: return P_MAKER[21:6];
      16'h0003: return {P_MAKER[5:0], P_MODEL, P_REV};
      16'h0004: return 16'h0011;
      16'h0005: return 16'h000B;
      16'h0006: return 16'h4000;
      16'h0008: return {4'hB, tx_l, rx_l, 10'h000};
      16'h000A: return {15'h0000, sig};
      default: return 16'h0000;
    endcase
  endfunction : exp_reg

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // Address frame then a read of the given kind
  task automatic rd(input logic [15:0] ofs, input logic [1:0] op, output logic [15:0] d);
    logic t;
    i_mgmt_station.frame(`OP_ADDRESS, P_PORT, `DEV_ADDR, ofs, t, d);
    i_mgmt_station.frame(op, P_PORT, `DEV_ADDR, 16'h0000, t, d);
    chk({15'h0000, t}, 16'h0000, "turnaround");
  endtask : rd

  // Read and compare; a status two read leaves only faults still present
  task automatic rc(input logic [15:0] ofs);
    logic [15:0] d;
    rd(ofs, `OP_READ, d);
    chk(d, exp_reg(ofs), "read word");
    if (ofs == 16'h0008) begin
      tx_l = tx_fault;
      rx_l = rx_fault;
    end
  endtask : rc

  // Short fault pulse, gone before the next read
  task automatic pulse(input logic t, input logic r);
    @(posedge ref_clk);
    tx_fault <= t;
    rx_fault <= r;
    repeat (8) @(posedge ref_clk);
    tx_fault <= 1'b0;
    rx_fault <= 1'b0;
    repeat (8) @(posedge ref_clk);
    tx_l = tx_l | t;
    rx_l = rx_l | r;
  endtask : pulse

  task automatic results();
    if (n_fail == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results

  // ----------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------------------------------
  initial begin
    forever #2 ref_clk = ~ref_clk;
  end

  initial begin
    repeat (90000) @(posedge ref_clk);
    n_fail++;
    $display("CHECK FAILED at %0t: run did not finish", $time);
    results();
  end

  initial begin : main
    logic [15:0] d;
    logic t;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    // Whole map after reset, unmapped words included
    for (int i = 0; i < 12; i++) rc(16'(i));
    // Writes must leave the words untouched
    for (int k = 0; k < 2; k++) begin
      d = k ? 16'h0008 : 16'h0003;
      i_mgmt_station.frame(`OP_ADDRESS, P_PORT, `DEV_ADDR, d, t, d);
      i_mgmt_station.frame(`OP_WRITE, P_PORT, `DEV_ADDR, 16'($random(seed)), t, d);
      rc(k ? 16'h0008 : 16'h0003);
    end
    // Post-read increment walks offsets 2 to 6: identity, speed and package words
    rd(16'h0002, `OP_POST_INC, d);
    chk(d, exp_reg(16'h0002), "post read");
    for (int k = 3; k < 7; k++) begin
      i_mgmt_station.frame(`OP_POST_INC, P_PORT, `DEV_ADDR, 16'h0000, t, d);
      chk(d, exp_reg(16'(k)), "post read");
    end
    // Foreign device or port: the line stays released
    i_mgmt_station.frame(`OP_READ, P_PORT, 5'($random(seed)) | 5'h02, 16'h0000, t, d);
    chk(d, 16'hFFFF, "foreign device");
    i_mgmt_station.frame(`OP_READ, P_PORT ^ 5'h01, `DEV_ADDR, 16'h0000, t, d);
    chk(d, 16'hFFFF, "foreign port");
    // Latched faults, summary bit and clear on read
    pulse(1'b1, 1'b0);
    rc(16'h0001);
    rc(16'h0008);
    rc(16'h0008);
    rc(16'h0001);
    pulse(1'b0, 1'b1);
    rc(16'h0008);
    // Faults still present at the read survive it: set wins over the clear
    @(posedge ref_clk);
    tx_fault <= 1'b1;
    rx_fault <= 1'b1;
    repeat (8) @(posedge ref_clk);
    tx_l = 1'b1;
    rx_l = 1'b1;
    rc(16'h0008);
    tx_fault <= 1'b0;
    rx_fault <= 1'b0;
    repeat (8) @(posedge ref_clk);
    rc(16'h0008);
    rc(16'h0008);
    // Reset in mid-run drops latched faults without any read
    pulse(1'b1, 1'b1);
    rst <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    tx_l = 1'b0;
    rx_l = 1'b0;
    repeat (4) @(posedge ref_clk);
    rc(16'h0008);
    rc(16'h0001);
    // Signal present reads back as one
    sig <= 1'b1;
    rc(16'h000A);
    sig <= 1'b0;
    // Random speeds, faults, signal level and offsets
    for (int k = 0; k < 16; k++) begin
      i_mgmt_station.half = 4 + ($random(seed) & 3);
      sig <= 1'($random(seed));
      pulse(1'($random(seed)), 1'($random(seed)));
      rc(16'($random(seed) & 15));
    end
    chk({15'h0000, clash}, 16'h0000, "line clash");
    results();
  end
endmodule : tb
`default_nettype wire
